// ==== hdl/ffcrs_consts.vh ====
// Contract
// - Dark pixels beside active area are not true dark; flag them. Code flags column 2230 and lines 32-33, 1506-1507 only, not column 45.
// - Test pixels at line ends may monitor horizontal transfer efficiency.
// - Both vertical phases stay low during integration.
// - Horizontal phase two high during vertical transfer; line lands on vertical one fall.
// - Horizontal phases toggle alternately and complementarily to shift pixels.
// - Pulse sense-node clear only after the pixel level is captured.
`ifndef FFCRS_CONSTS_VH
`define FFCRS_CONSTS_VH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define FFCRS_LINES        1510
`define FFCRS_HPIX         2267
`define FFCRS_TOP_DARK     34
`define FFCRS_BOT_DARK     4
`define FFCRS_ACT_LINES    1472
// Pixel segment ends (exclusive) inside a line
`define FFCRS_SEG_DUMMY    8
`define FFCRS_SEG_TEST1    9
`define FFCRS_SEG_INACT    12
`define FFCRS_SEG_REF      46
`define FFCRS_SEG_ACT      2230
`define FFCRS_SEG_DARK2    2264
`define FFCRS_SEG_TEST2    2265
// Pixel class codes
`define FFCRS_CLS_INACT    2'h0
`define FFCRS_CLS_DARK     2'h1
`define FFCRS_CLS_TEST     2'h2
`define FFCRS_CLS_ACT      2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define FFCRS_CLK_MHZ      200
`define FFCRS_MAX_PIX_MHZ  15
// Quarter-pixel ticks: 4 ticks per pixel, ceil(200/(15*4)) = 4 cycles
`define FFCRS_TICK_DIV     ((`FFCRS_CLK_MHZ + 4*`FFCRS_MAX_PIX_MHZ - 1) / (4*`FFCRS_MAX_PIX_MHZ))
`define FFCRS_VPH_TICKS    8
`endif

// ==== hdl/ffcrs_tick.v ====
`timescale 1ns/1ps
`include "ffcrs_consts.vh"
module ffcrs_tick #(
   parameter DIV = `FFCRS_TICK_DIV
) (
   input  wire       clk_i,
   input  wire       nrst_i,
   input  wire       en_i,
   output wire       tick_o
);
   reg  [7:0]  cnt_r;
   wire [31:0] lim_w = DIV - 1;
   wire [7:0]  lim   = lim_w[7:0];
   assign tick_o = en_i && (cnt_r == lim);
   always @(posedge clk_i) begin
      if (!nrst_i || !en_i || tick_o) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
endmodule

// ==== hdl/ffcrs_seq.v ====
`timescale 1ns/1ps
`include "ffcrs_consts.vh"
module ffcrs_seq #(
   parameter LINES   = `FFCRS_LINES,
   parameter HPIX    = `FFCRS_HPIX,
   parameter TICKDIV = `FFCRS_TICK_DIV,
   parameter VTICKS  = `FFCRS_VPH_TICKS
) (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        start_i,
   input  wire        integrate_i,
   input  wire [13:0] video_i,
   output reg         vertical_phase_one_o,
   output reg         vertical_phase_two_o,
   output reg         horizontal_phase_one_o,
   output reg         horizontal_phase_two_o,
   output reg         sense_node_clear_o,
   output reg         busy_o,
   output reg         integrating_o,
   output reg         frame_done_o,
   output reg         pix_valid_o,
   output reg  [13:0] pix_data_o,
   output reg  [11:0] pix_col_o,
   output reg  [10:0] pix_line_o,
   output reg  [1:0]  pix_class_o,
   output reg         pix_edge_o
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_INTEG = 5'h02;
   localparam [4:0] S_VXFER = 5'h04;
   localparam [4:0] S_HSHFT = 5'h08;
   localparam [4:0] S_DONE  = 5'h10;

   reg  [4:0]  state_r;
   reg  [1:0]  phase_r;
   reg  [3:0]  vcnt_r;
   reg  [11:0] col_r;
   reg  [10:0] line_r;
   reg  [13:0] vid_s1_r;
   reg  [13:0] vid_s2_r;
   reg         start_s1_r;
   reg         start_s2_r;
   reg         integ_s1_r;
   reg         integ_s2_r;
   reg         start_d_r;
   reg  [1:0]  cls_nxt;
   reg         edge_nxt;
   wire        tick;
   wire        run = (state_r == S_VXFER) || (state_r == S_HSHFT);
   wire [31:0] hlast_w = HPIX - 1;
   wire [31:0] llast_w = LINES - 1;
   wire [31:0] vlast_w = VTICKS - 1;
   wire [11:0] hlast   = hlast_w[11:0];
   wire [10:0] llast   = llast_w[10:0];
   wire [3:0]  vlast   = vlast_w[3:0];

   ffcrs_tick #(.DIV(TICKDIV)) u_tick (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .en_i   (run),
      .tick_o (tick)
   );

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         vid_s1_r   <= 14'h0000;
         vid_s2_r   <= 14'h0000;
         start_s1_r <= 1'b0;
         start_s2_r <= 1'b0;
         integ_s1_r <= 1'b0;
         integ_s2_r <= 1'b0;
         start_d_r  <= 1'b0;
      end else begin
         vid_s1_r   <= video_i;
         vid_s2_r   <= vid_s1_r;
         start_s1_r <= start_i;
         start_s2_r <= start_s1_r;
         integ_s1_r <= integrate_i;
         integ_s2_r <= integ_s1_r;
         start_d_r  <= start_s2_r;
      end
   end
   wire start_rise = start_s2_r && !start_d_r;

   // ----------------------------------------
   // Pixel classification
   // ----------------------------------------
   always @* begin
      cls_nxt  = `FFCRS_CLS_INACT;
      edge_nxt = 1'b0;
      if (col_r < `FFCRS_SEG_DUMMY) begin
         cls_nxt = `FFCRS_CLS_DARK;
      end else if (col_r < `FFCRS_SEG_TEST1) begin
         cls_nxt = `FFCRS_CLS_TEST;
      end else if (col_r < `FFCRS_SEG_INACT) begin
         cls_nxt = `FFCRS_CLS_INACT;
      end else if (col_r < `FFCRS_SEG_REF) begin
         cls_nxt = `FFCRS_CLS_DARK;
      end else if (col_r < `FFCRS_SEG_ACT) begin
         cls_nxt = `FFCRS_CLS_ACT;
      end else if (col_r < `FFCRS_SEG_DARK2) begin
         cls_nxt = `FFCRS_CLS_DARK;
         edge_nxt = (col_r == `FFCRS_SEG_ACT);
      end else if (col_r < `FFCRS_SEG_TEST2) begin
         cls_nxt = `FFCRS_CLS_TEST;
      end
      // Shielded top and bottom lines turn the active column class into dark
      if (line_r < `FFCRS_TOP_DARK ||
          line_r >= `FFCRS_TOP_DARK + `FFCRS_ACT_LINES) begin
         if (cls_nxt == `FFCRS_CLS_ACT) begin
            cls_nxt = `FFCRS_CLS_DARK;
         end
         if (line_r == `FFCRS_TOP_DARK - 2 || line_r == `FFCRS_TOP_DARK - 1 ||
             line_r == `FFCRS_TOP_DARK + `FFCRS_ACT_LINES ||
             line_r == `FFCRS_TOP_DARK + `FFCRS_ACT_LINES + 1) begin
            edge_nxt = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Sequencer
   // Four ticks per pixel: H1 high, H1 fall, sample, clear.
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (!nrst_i) begin
         state_r                <= S_IDLE;
         phase_r                <= 2'h0;
         vcnt_r                 <= 4'h0;
         col_r                  <= 12'h000;
         line_r                 <= 11'h000;
         vertical_phase_one_o   <= 1'b0;
         vertical_phase_two_o   <= 1'b0;
         horizontal_phase_one_o <= 1'b0;
         horizontal_phase_two_o <= 1'b1;
         sense_node_clear_o     <= 1'b0;
         busy_o                 <= 1'b0;
         integrating_o          <= 1'b0;
         frame_done_o           <= 1'b0;
         pix_valid_o            <= 1'b0;
         pix_data_o             <= 14'h0000;
         pix_col_o              <= 12'h000;
         pix_line_o             <= 11'h000;
         pix_class_o            <= `FFCRS_CLS_INACT;
         pix_edge_o             <= 1'b0;
      end else begin
         frame_done_o <= 1'b0;
         pix_valid_o  <= 1'b0;
         case (state_r)
            S_IDLE: begin
               vertical_phase_one_o <= 1'b0;
               vertical_phase_two_o <= 1'b0;
               busy_o               <= 1'b0;
               if (integ_s2_r) begin
                  state_r       <= S_INTEG;
                  busy_o        <= 1'b1;
                  integrating_o <= 1'b1;
               end else if (start_rise) begin
                  state_r <= S_VXFER;
                  busy_o  <= 1'b1;
                  line_r  <= 11'h000;
                  vcnt_r  <= 4'h0;
               end
            end
            S_INTEG: begin
               vertical_phase_one_o <= 1'b0;
               vertical_phase_two_o <= 1'b0;
               if (!integ_s2_r) begin
                  integrating_o <= 1'b0;
                  state_r       <= S_VXFER;
                  line_r        <= 11'h000;
                  vcnt_r        <= 4'h0;
               end
            end
            S_VXFER: begin
               horizontal_phase_one_o <= 1'b0;
               horizontal_phase_two_o <= 1'b1;
               if (tick) begin
                  vcnt_r <= vcnt_r + 4'h1;
                  // Node held clear since the last pixel; release before the first packet
                  sense_node_clear_o <= 1'b0;
                  // V1 high first half, V2 high from the second quarter until the last tick; V1 falls mid-step
                  vertical_phase_one_o <= (vcnt_r < (VTICKS / 2));
                  vertical_phase_two_o <= (vcnt_r >= (VTICKS / 4)) &&
                                          (vcnt_r < VTICKS - 1);
                  if (vcnt_r == vlast) begin
                     vertical_phase_one_o <= 1'b0;
                     vertical_phase_two_o <= 1'b0;
                     state_r <= S_HSHFT;
                     col_r   <= 12'h000;
                     phase_r <= 2'h0;
                  end
               end
            end
            S_HSHFT: begin
               if (tick) begin
                  phase_r <= phase_r + 2'h1;
                  case (phase_r)
                     2'h0: begin
                        horizontal_phase_one_o <= 1'b1;
                        horizontal_phase_two_o <= 1'b0;
                        sense_node_clear_o     <= 1'b0;
                     end
                     2'h1: begin
                        // Packet lands on sense node here
                        horizontal_phase_one_o <= 1'b0;
                        horizontal_phase_two_o <= 1'b1;
                     end
                     2'h2: begin
                        pix_valid_o <= 1'b1;
                        pix_data_o  <= ~vid_s2_r;
                        pix_col_o   <= col_r;
                        pix_line_o  <= line_r;
                        pix_class_o <= cls_nxt;
                        pix_edge_o  <= edge_nxt;
                     end
                     default: begin
                        sense_node_clear_o <= 1'b1;
                        col_r <= col_r + 12'h001;
                        // Last pixel is cleared too, else it joins the next line's first
                        if (col_r == hlast) begin
                           if (line_r == llast) begin
                              state_r <= S_DONE;
                           end else begin
                              line_r  <= line_r + 11'h001;
                              vcnt_r  <= 4'h0;
                              state_r <= S_VXFER;
                           end
                        end
                     end
                  endcase
               end
            end
            S_DONE: begin
               horizontal_phase_one_o <= 1'b0;
               horizontal_phase_two_o <= 1'b1;
               frame_done_o           <= 1'b1;
               busy_o                 <= 1'b0;
               state_r                <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// ==== tb/ffcrs_seq_properties.sv ====
`timescale 1ns/1ps
`include "ffcrs_consts.vh"
module ffcrs_seq_properties (
   input wire        clk_i,
   input wire        nrst_i,
   input wire        vertical_phase_one_o,
   input wire        vertical_phase_two_o,
   input wire        horizontal_phase_one_o,
   input wire        horizontal_phase_two_o,
   input wire        sense_node_clear_o,
   input wire        busy_o,
   input wire        integrating_o,
   input wire        frame_done_o,
   input wire        pix_valid_o,
   input wire [11:0] pix_col_o,
   input wire [1:0]  pix_class_o
);
   // ----------------------------------------
   // Sequencing properties
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // At least 14 cycles between samples keeps the pixel rate under 15 MHz
   sequence s_quiet;
      (!pix_valid_o)[*8] ##1 (!pix_valid_o)[*5];
   endsequence
   sequence s_vxfer_hold;
      horizontal_phase_two_o && !horizontal_phase_one_o;
   endsequence
   chk_integrate_low: assert property (
      integrating_o |-> !vertical_phase_one_o && !vertical_phase_two_o)
      else $error("vertical phase high while integrating");
   chk_h2_in_vxfer: assert property (
      (vertical_phase_one_o || vertical_phase_two_o) |-> s_vxfer_hold)
      else $error("horizontal phases wrong during vertical transfer");
   chk_line_on_fall: assert property (
      $fell(vertical_phase_one_o) |-> s_vxfer_hold ##1 s_vxfer_hold)
      else $error("line delivered without horizontal phase two high");
   chk_v_order: assert property (
      $rose(vertical_phase_two_o) |-> vertical_phase_one_o)
      else $error("vertical phase two rose without phase one");
   chk_h_complement: assert property (
      busy_o && !integrating_o |-> horizontal_phase_one_o != horizontal_phase_two_o)
      else $error("horizontal phases not complementary");
   chk_clear_after: assert property (
      pix_valid_o |-> !sense_node_clear_o ##1 !sense_node_clear_o)
      else $error("sense node cleared before sample");
   chk_pixel_rate: assert property (
      pix_valid_o |=> s_quiet)
      else $error("pixel rate too high");
   chk_test_class: assert property (
      pix_valid_o && pix_col_o == 12'h008 |-> pix_class_o == `FFCRS_CLS_TEST)
      else $error("test pixel class wrong");
   chk_done_pulse: assert property (
      frame_done_o |=> !frame_done_o && !pix_valid_o)
      else $error("frame done not a single pulse");
endmodule
bind ffcrs_seq ffcrs_seq_properties u_props (.clk_i, .nrst_i, .vertical_phase_one_o,
   .vertical_phase_two_o, .horizontal_phase_one_o, .horizontal_phase_two_o,
   .sense_node_clear_o, .busy_o, .integrating_o, .frame_done_o, .pix_valid_o,
   .pix_col_o, .pix_class_o);

// ==== tb/ffcrs_ccd_model.sv ====
`timescale 1ns/1ps
module ffcrs_ccd_model #(
   parameter LINES = 1510
) (
   input  wire        clk_i,
   input  wire        nrst_i,
   input  wire        vertical_phase_one_i,
   input  wire        horizontal_phase_one_i,
   input  wire        sense_node_clear_i,
   output reg  [13:0] video_o
);
   // ----------------------------------------
   // Sensor behaviour, position-coded charge
   // ----------------------------------------
   reg [10:0] row_r;
   reg [11:0] col_r;
   reg        v1_d_r, h1_d_r, clr_d_r;
   always @(posedge clk_i) begin
      v1_d_r  <= vertical_phase_one_i;
      h1_d_r  <= horizontal_phase_one_i;
      clr_d_r <= sense_node_clear_i;
      if (!nrst_i) begin
         row_r   <= 11'(LINES - 1);
         col_r   <= 12'h000;
         video_o <= 14'h3fff;
      end else begin
         if (v1_d_r && !vertical_phase_one_i) begin
            row_r <= (row_r == 11'(LINES - 1)) ? 11'h000 : row_r + 11'h001;
            col_r <= 12'h000;
         end
         if (h1_d_r && !horizontal_phase_one_i) begin
            video_o <= ~{row_r[2:0], col_r[10:0]};
            col_r   <= col_r + 12'h001;
         end
         if (!clr_d_r && sense_node_clear_i) video_o <= 14'h3fff;
      end
   end
endmodule

// ==== tb/test_full_frame_ccd_readout_sequencer.sv ====
`timescale 1ns/1ps
`include "ffcrs_consts.vh"
module test_full_frame_ccd_readout_sequencer;
   // ----------------------------------------
   // Short lines; 35 lines reach the first active line
   // ----------------------------------------
   localparam LINES    = 35;
   localparam HPIX     = 50;
   localparam EDGE0    = `FFCRS_TOP_DARK - 2;
   // Per line: 8 vertical ticks plus 4 ticks per pixel, 4 cycles a tick
   localparam WAIT_LIM = LINES * (HPIX * 16 + 32) + 500;
   reg         clk_i, nrst_i, start_i, integrate_i;
   wire [13:0] video_i, pix_data;
   wire        v1, v2, h1, h2, clr, busy, integ, done, valid, pedge;
   wire [11:0] pix_col;
   wire [10:0] pix_line;
   wire [1:0]  pix_class;
   integer     mismatches, cmp_count, n, i, dones, ln;
   reg [1:0]   exp_cls;
   reg [1:0]   cls_seen [0:HPIX-1];
   reg [1:0]   cls_act  [0:HPIX-1];
   reg [13:0]  rows [0:6];
   ffcrs_seq #(.LINES(LINES), .HPIX(HPIX)) uut (.clk_i, .nrst_i, .start_i, .integrate_i,
      .video_i, .vertical_phase_one_o(v1), .vertical_phase_two_o(v2),
      .horizontal_phase_one_o(h1), .horizontal_phase_two_o(h2), .sense_node_clear_o(clr),
      .busy_o(busy), .integrating_o(integ), .frame_done_o(done), .pix_valid_o(valid),
      .pix_data_o(pix_data), .pix_col_o(pix_col), .pix_line_o(pix_line),
      .pix_class_o(pix_class), .pix_edge_o(pedge));
   ffcrs_ccd_model #(.LINES(LINES)) u_ccd (.clk_i, .nrst_i, .vertical_phase_one_i(v1),
      .horizontal_phase_one_i(h1), .sense_node_clear_i(clr), .video_o(video_i));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task end_of_test;
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task wait_done(input integer tgt);
      integer t;
      t = 0;
      while (dones < tgt && t < WAIT_LIM) begin
         @(posedge clk_i);
         t = t + 1;
      end
      if (t >= WAIT_LIM) mismatches = mismatches + 1;
      #1;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (done === 1'b1) dones = dones + 1;
      if (valid === 1'b1) begin
         ln = n / HPIX;
         chk("pix_edge", {15'h0000, pedge}, 16'(ln == EDGE0 || ln == EDGE0 + 1));
         chk("pix_col", {4'h0, pix_col}, 16'(n % HPIX));
         chk("pix_line", {5'h00, pix_line}, 16'(n / HPIX));
         chk("pix_data", {2'h0, pix_data}, 16'((n / HPIX % 8) * 2048 + n % HPIX));
         if (n < HPIX) cls_seen[n] = pix_class;
         if (ln == `FFCRS_TOP_DARK) cls_act[n % HPIX] = pix_class;
         n = n + 1;
      end
   end
   initial begin
      repeat (2 * WAIT_LIM + 2000) @(posedge clk_i);
      mismatches = mismatches + 1;
      end_of_test;
   end
   initial begin
      mismatches = 0;
      cmp_count = 0;
      n = 0;
      dones = 0;
      ln = 0;
      nrst_i = 1'b0;
      start_i = 1'b0;
      integrate_i = 1'b0;
      rows[0] = {12'h008, `FFCRS_CLS_TEST};
      rows[1] = {12'h009, `FFCRS_CLS_INACT};
      rows[2] = {12'h00b, `FFCRS_CLS_INACT};
      rows[3] = {12'h00c, `FFCRS_CLS_DARK};
      rows[4] = {12'h02d, `FFCRS_CLS_DARK};
      rows[5] = {12'h02e, `FFCRS_CLS_ACT};
      rows[6] = {12'h031, `FFCRS_CLS_ACT};
      repeat (8) @(posedge clk_i);
      #1 chk("reset_outs", {7'h00, v1, v2, h1, h2, clr, busy, integ, done, valid}, 16'h0020);
      @(posedge clk_i) nrst_i <= 1'b1;
      @(posedge clk_i) start_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      #1 chk("busy", {15'h0000, busy}, 16'h0001);
      // Retrigger attempts mid-frame must be ignored
      @(posedge clk_i) start_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      start_i <= 1'b1; integrate_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      start_i <= 1'b0; integrate_i <= 1'b0;
      wait_done(1);
      chk("pixel_count", 16'(n), 16'(LINES * HPIX));
      // Shielded top line 0 shows no active class; line 34 shows the column classes
      for (i = 0; i < 7; i = i + 1) begin
         exp_cls = (rows[i][1:0] == `FFCRS_CLS_ACT) ? `FFCRS_CLS_DARK : rows[i][1:0];
         chk("dark_class", 16'(cls_seen[rows[i][13:2]]), 16'(exp_cls));
         chk("pix_class", 16'(cls_act[rows[i][13:2]]), 16'(rows[i][1:0]));
      end
      repeat (100) @(posedge clk_i);
      #1 chk("frames", 16'(dones) + {15'h0000, busy}, 16'h0001);
      // Integration, then readout on its release
      n = 0;
      @(posedge clk_i) integrate_i <= 1'b1;
      repeat (60) @(posedge clk_i);
      #1 chk("integrate", {13'h0000, integ, v1, v2}, 16'h0004);
      @(posedge clk_i) integrate_i <= 1'b0;
      wait_done(2);
      chk("pixel_count2", 16'(n), 16'(LINES * HPIX));
      end_of_test;
   end
endmodule
